// ### rtl/fault_sup.sv
// Transfer fault supervisor: fault flags, alert, engine stop, module table, event log
// Assumes synchronous inputs, APB requester, external timers that flag expiry
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
module fault_sup (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pos_pref_sw,
  input wire logic pos_stby_sw,
  input wire logic xfer_cmd,
  input wire logic xfer_done_tmo,
  input wire logic src_avail_chg,
  input wire logic acq_stby_tmo,
  input wire logic acq_pref_tmo,
  input wire logic in_phase_monitor,
  input wire logic sync_tmo,
  input wire logic backup_battery_module_low,
  input wire logic rot_err_n,
  input wire logic rot_err_e,
  input wire logic [3:0] mod_present,
  input wire logic [3:0] mod_comm_ok,
  input wire logic [7:0] mod_type_in,
  input wire logic ext_fault_in,
  input wire logic cooldown_done,
  input wire logic [7:0] event_code,
  input wire logic event_valid,
  output logic alert_led,
  output logic [12:0] fault_out,
  output logic common_fault,
  output logic [3:0] fault_msg,
  output logic halt_xfer,
  output logic modes_off,
  output logic cooldown_start,
  output logic engine_start,
  output logic xfer_retry,
  output logic check_mod_setup,
  output logic [3:0] data_reset_go
);
  localparam int NM = fault_sup_pkg::NUM_MOD;
  localparam int NF = fault_sup_pkg::NUM_FLT;
  logic [NF-1:0] flag_r;
  logic [31:0] ctrl_r;
  logic [NM-1:0] inst_r;
  logic [1:0] mtype_r [NM];
  logic [2:0] pos_filt_pref_r, pos_filt_stby_r;
  logic [NM-1:0] pres_f_r;
  logic [1:0] tries_r;
  logic pos_pref_q_r, pos_stby_q_r, xfer_pend_r;
  logic [7:0] log_mem_r [fault_sup_pkg::LOG_DEPTH];
  logic [6:0] log_wp_r, log_cnt_r, log_rd_r;
  logic [31:0] flash_cnt_r;
  fault_sup_pkg::eng_e eng_r;
  logic wr_acc, rd_acc, cmd_rst, cmd_ack, cmd_save, cmd_back, cmd_hist;
  logic pref_ok, stby_ok, lost_any, new_any;
  logic pos_valid_r, pos_valid_d_r, pref_prev_r, stby_prev_r, pref_steady, stby_steady, pos_moved;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign wr_acc = psel & penable & pwrite & ~pready;
  assign rd_acc = psel & penable & ~pwrite & ~pready;
  assign cmd_rst = wr_acc && paddr == fault_sup_pkg::A_CMD && pwdata[fault_sup_pkg::C_FAULT_RST];
  assign cmd_ack = wr_acc && paddr == fault_sup_pkg::A_CMD
                   && pwdata[fault_sup_pkg::C_NEW_MOD_ACK];
  assign cmd_save = wr_acc && paddr == fault_sup_pkg::A_CMD && pwdata[fault_sup_pkg::C_SAVE];
  assign cmd_back = wr_acc && paddr == fault_sup_pkg::A_CMD && pwdata[fault_sup_pkg::C_BACK];
  assign cmd_hist = wr_acc && paddr == fault_sup_pkg::A_CMD && pwdata[fault_sup_pkg::C_HIST_RST];

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        if (paddr > fault_sup_pkg::A_MODINFO || paddr[1:0] != 2'h0) begin
          pslverr <= 1'b1;
        end
      end
      if (rd_acc) begin
        unique case (paddr)
          fault_sup_pkg::A_STATUS: prdata <= {19'h0, flag_r};
          fault_sup_pkg::A_CTRL: prdata <= ctrl_r;
          fault_sup_pkg::A_MODTYPE: prdata <= {24'h0, mtype_r[3], mtype_r[2], mtype_r[1],
                                               mtype_r[0]};
          fault_sup_pkg::A_LOGCNT: prdata <= {25'h0, log_cnt_r};
          fault_sup_pkg::A_LOGDATA: prdata <= {24'h0, log_mem_r[log_rd_r]};
          fault_sup_pkg::A_MODINFO: prdata <= {28'h0, inst_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= fault_sup_pkg::CTRL_RST;
      log_rd_r <= 7'h00;
    end else if (wr_acc && paddr == fault_sup_pkg::A_CTRL) begin
      ctrl_r <= pwdata;
    end else if (wr_acc && paddr == fault_sup_pkg::A_LOGCNT) begin
      log_rd_r <= pwdata[6:0];
    end
  end

  // ------------------------------------------------------------
  // Input filters
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_filt_pref_r <= 3'h0;
      pos_filt_stby_r <= 3'h0;
      pos_pref_q_r <= 1'b0;
      pos_stby_q_r <= 1'b0;
      pos_valid_r <= 1'b0;
      pos_valid_d_r <= 1'b0;
      pref_prev_r <= 1'b0;
      stby_prev_r <= 1'b0;
    end else begin
      pos_filt_pref_r <= {pos_filt_pref_r[1:0], pos_pref_sw};
      pos_filt_stby_r <= {pos_filt_stby_r[1:0], pos_stby_sw};
      pref_prev_r <= pos_pref_q_r;
      stby_prev_r <= pos_stby_q_r;
      pos_valid_d_r <= pos_valid_r;
      // No position fault until both filters have settled once after reset
      if (pref_steady && stby_steady) pos_valid_r <= 1'b1;
      if (pos_filt_pref_r == 3'h7 && pos_pref_sw) pos_pref_q_r <= 1'b1;
      else if (pos_filt_pref_r == 3'h0 && !pos_pref_sw) pos_pref_q_r <= 1'b0;
      if (pos_filt_stby_r == 3'h7 && pos_stby_sw) pos_stby_q_r <= 1'b1;
      else if (pos_filt_stby_r == 3'h0 && !pos_stby_sw) pos_stby_q_r <= 1'b0;
    end
  end
  assign pref_ok = pos_pref_q_r;
  assign stby_ok = pos_stby_q_r;
  assign pref_steady = (pos_filt_pref_r == 3'h7 && pos_pref_sw)
                       || (pos_filt_pref_r == 3'h0 && !pos_pref_sw);
  assign stby_steady = (pos_filt_stby_r == 3'h7 && pos_stby_sw)
                       || (pos_filt_stby_r == 3'h0 && !pos_stby_sw);
  // Filtered contactor arrived at a new single position
  assign pos_moved = pos_valid_d_r && (pref_ok ^ stby_ok)
                     && (pref_ok != pref_prev_r || stby_ok != stby_prev_r);

  genvar gi;
  generate
    for (gi = 0; gi < NM; gi++) begin : g_mod
      logic [2:0] sh_r;
      always_ff @(posedge clk) begin
        if (rst) begin
          sh_r <= 3'h0;
          pres_f_r[gi] <= 1'b0;
        end else begin
          sh_r <= {sh_r[1:0], mod_present[gi]};
          if (sh_r == 3'h7 && mod_present[gi]) pres_f_r[gi] <= 1'b1;
          else if (sh_r == 3'h0 && !mod_present[gi]) pres_f_r[gi] <= 1'b0;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          inst_r[gi] <= 1'b0;
          mtype_r[gi] <= fault_sup_pkg::NO_BOARD_TYPE;
        end else if (cmd_ack && pres_f_r[gi] && !inst_r[gi]) begin
          inst_r[gi] <= 1'b1;
          mtype_r[gi] <= mod_type_in[2*gi +: 2];
        end else if (cmd_save && ctrl_r[fault_sup_pkg::K_UNINST_YES]
                     && ctrl_r[fault_sup_pkg::K_MOD_SEL +: 2] == 2'(gi)
                     && inst_r[gi] && !pres_f_r[gi]) begin
          inst_r[gi] <= 1'b0;
          mtype_r[gi] <= fault_sup_pkg::NO_BOARD_TYPE;
        end
      end
    end
  endgenerate
  assign lost_any = |(inst_r & ~pres_f_r);
  assign new_any = |(~inst_r & pres_f_r);

  // ------------------------------------------------------------
  // Fault flags
  // ------------------------------------------------------------
  logic [NF-1:0] set_v, clr_v, conf_v;
  always_comb begin
    set_v = '0;
    clr_v = '0;
    conf_v = '0;
    for (int i = 0; i < NM; i++) begin
      if (inst_r[i] && pres_f_r[i] && mtype_r[i] != mod_type_in[2*i +: 2])
        conf_v[fault_sup_pkg::F_MOD_CONF] = 1'b1;
    end
    set_v[fault_sup_pkg::F_FTA_STBY] = acq_stby_tmo;
    set_v[fault_sup_pkg::F_FTA_PREF] = acq_pref_tmo;
    set_v[fault_sup_pkg::F_SYNC] = sync_tmo & ~in_phase_monitor;
    set_v[fault_sup_pkg::F_BATT] = backup_battery_module_low;
    set_v[fault_sup_pkg::F_FTT] = xfer_pend_r && xfer_done_tmo
      && tries_r == 2'(fault_sup_pkg::XFER_TRIES - 1);
    set_v[fault_sup_pkg::F_ROT_N] = rot_err_n;
    set_v[fault_sup_pkg::F_ROT_E] = rot_err_e;
    set_v[fault_sup_pkg::F_COMM] = |(inst_r & pres_f_r & ~mod_comm_ok);
    set_v[fault_sup_pkg::F_AUX] = (pos_valid_r & pref_ok & stby_ok)
      | (!xfer_pend_r && pos_moved);
    set_v[fault_sup_pkg::F_AUX_OPEN] = pos_valid_r & ~pref_ok & ~stby_ok & ~xfer_pend_r;
    set_v[fault_sup_pkg::F_MOD_CHG] = lost_any | new_any;
    set_v[fault_sup_pkg::F_MOD_CONF] = conf_v[fault_sup_pkg::F_MOD_CONF];
    set_v[fault_sup_pkg::F_EXT] = ext_fault_in;
    if (src_avail_chg || xfer_cmd) clr_v = clr_v | fault_sup_pkg::WARN_MASK;
    if (in_phase_monitor) clr_v[fault_sup_pkg::F_SYNC] = 1'b1;
    clr_v = clr_v | (fault_sup_pkg::SELF_MASK & ~set_v);
    if (cmd_rst) begin
      clr_v = clr_v | fault_sup_pkg::WARN_MASK | fault_sup_pkg::MAN_MASK;
      if (lost_any) clr_v[fault_sup_pkg::F_MOD_CHG] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) flag_r <= '0;
    else flag_r <= (flag_r & ~clr_v) | set_v;
  end

  always_ff @(posedge clk) begin
    if (rst) check_mod_setup <= 1'b0;
    else if (cmd_rst && lost_any) check_mod_setup <= 1'b1;
    else if (!lost_any) check_mod_setup <= 1'b0;
  end

  // ------------------------------------------------------------
  // Transfer retry
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tries_r <= 2'h0;
      xfer_pend_r <= 1'b0;
      xfer_retry <= 1'b0;
    end else begin
      xfer_retry <= 1'b0;
      if (xfer_cmd) begin
        xfer_pend_r <= 1'b1;
        tries_r <= 2'h0;
      end else if (xfer_pend_r && xfer_done_tmo) begin
        if (tries_r == 2'(fault_sup_pkg::XFER_TRIES - 1)) begin
          xfer_pend_r <= 1'b0;
        end else begin
          tries_r <= tries_r + 2'h1;
          xfer_retry <= 1'b1;
        end
      end else if (pos_moved) begin
        xfer_pend_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs, alert, engine
  // ------------------------------------------------------------
  logic [3:0] msg_v;
  always_comb begin
    msg_v = 4'hf;
    for (int i = NF - 1; i >= 0; i--) if (flag_r[i]) msg_v = 4'(i);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flash_cnt_r <= 32'h0;
      alert_led <= 1'b0;
      fault_out <= '0;
      common_fault <= 1'b0;
      fault_msg <= 4'hf;
      halt_xfer <= 1'b0;
      modes_off <= 1'b0;
    end else begin
      // Counter rests at zero while idle so the indicator lights at once
      if (flag_r == '0) flash_cnt_r <= 32'h0;
      else flash_cnt_r <= (flash_cnt_r == 32'(fault_sup_pkg::FLASH_CYC - 1)) ? 32'h0
                          : flash_cnt_r + 32'h1;
      if (flag_r == '0) alert_led <= 1'b0;
      else if (flash_cnt_r == 32'h0) alert_led <= ~alert_led;
      fault_out <= flag_r;
      common_fault <= |flag_r;
      fault_msg <= msg_v;
      halt_xfer <= |(flag_r & fault_sup_pkg::MAN_MASK);
      modes_off <= |(flag_r & (fault_sup_pkg::MAN_MASK | fault_sup_pkg::SELF_MASK));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eng_r <= fault_sup_pkg::ENG_RUN;
      engine_start <= 1'b1;
      cooldown_start <= 1'b0;
    end else begin
      cooldown_start <= 1'b0;
      unique case (eng_r)
        fault_sup_pkg::ENG_RUN: begin
          engine_start <= 1'b1;
          if (modes_off && pref_ok) begin
            eng_r <= fault_sup_pkg::ENG_COOL;
            cooldown_start <= 1'b1;
          end
        end
        fault_sup_pkg::ENG_COOL: if (cooldown_done) begin
          eng_r <= fault_sup_pkg::ENG_OFF;
          engine_start <= 1'b0;
        end
        fault_sup_pkg::ENG_OFF: if (!modes_off) eng_r <= fault_sup_pkg::ENG_RUN;
        default: eng_r <= fault_sup_pkg::ENG_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Data reset and event log
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) data_reset_go <= 4'h0;
    else if (cmd_save && !cmd_back && ctrl_r[fault_sup_pkg::K_DATA_YES])
      data_reset_go <= 4'h1 << ctrl_r[fault_sup_pkg::K_DATA_SEL +: 2];
    else data_reset_go <= 4'h0;
  end

  always_ff @(posedge clk) begin
    if (rst || cmd_hist) begin
      log_wp_r <= 7'h00;
      log_cnt_r <= 7'h00;
    end else if (event_valid) begin
      log_mem_r[log_wp_r] <= event_code;
      log_wp_r <= (log_wp_r == 7'(fault_sup_pkg::LOG_DEPTH - 1)) ? 7'h00 : log_wp_r + 7'h1;
      if (log_cnt_r != 7'(fault_sup_pkg::LOG_DEPTH)) log_cnt_r <= log_cnt_r + 7'h1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_common_or: assert property (@(posedge clk) disable iff (rst)
    common_fault == |$past(flag_r)) else $error("common fault not OR of flags");
  a_ext_follow: assert property (@(posedge clk) disable iff (rst)
    ext_fault_in |=> flag_r[fault_sup_pkg::F_EXT]) else $error("external fault missed");
  a_sync_clear: assert property (@(posedge clk) disable iff (rst)
    in_phase_monitor && !sync_tmo |=> !flag_r[fault_sup_pkg::F_SYNC])
    else $error("sync warning stuck");
  a_halt_man: assert property (@(posedge clk) disable iff (rst)
    flag_r[fault_sup_pkg::F_AUX_OPEN] |=> halt_xfer) else $error("no halt on manual fault");
  a_lost_persist: assert property (@(posedge clk) disable iff (rst)
    lost_any && flag_r[fault_sup_pkg::F_MOD_CHG] |=> flag_r[fault_sup_pkg::F_MOD_CHG])
    else $error("lost module fault cleared");
  a_rot_self: assert property (@(posedge clk) disable iff (rst)
    !rot_err_n |=> !flag_r[fault_sup_pkg::F_ROT_N]) else $error("rotation fault stuck");
  a_batt_warn: assert property (@(posedge clk) disable iff (rst)
    backup_battery_module_low |=> flag_r[fault_sup_pkg::F_BATT]) else $error("battery missed");
  a_data_back: assert property (@(posedge clk) disable iff (rst)
    cmd_back |=> data_reset_go == 4'h0) else $error("back changed data");
  c_ftt: cover property (@(posedge clk) flag_r[fault_sup_pkg::F_FTT]);
  c_cool: cover property (@(posedge clk) eng_r == fault_sup_pkg::ENG_COOL ##1 !engine_start);
  c_ack: cover property (@(posedge clk) cmd_ack ##1 |inst_r);
endmodule

// ### rtl/fault_sup_pkg.sv
// Constants, types and register map of the transfer fault supervisor
// Assumes a single 100 MHz clock and an APB requester outside
package fault_sup_pkg;
  localparam int NUM_MOD = 4;
  localparam int NUM_FLT = 13;
  localparam int FILT_LEN = 4;
  localparam int LOG_DEPTH = 100;
  localparam int CLK_MHZ = 100;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam int XFER_TRIES = 3;
  localparam logic [1:0] NO_BOARD_TYPE = 2'h0;
  localparam logic [1:0] ALARM_BOARD_TYPE = 2'h1;
  localparam logic [1:0] STANDARD_IO_BOARD_TYPE = 2'h2;
  localparam logic [1:0] HIGH_POWER_IO_BOARD_TYPE = 2'h3;
  // Flag positions
  localparam int F_FTA_STBY = 0;
  localparam int F_FTA_PREF = 1;
  localparam int F_SYNC = 2;
  localparam int F_BATT = 3;
  localparam int F_FTT = 4;
  localparam int F_ROT_N = 5;
  localparam int F_ROT_E = 6;
  localparam int F_COMM = 7;
  localparam int F_AUX = 8;
  localparam int F_AUX_OPEN = 9;
  localparam int F_MOD_CHG = 10;
  localparam int F_MOD_CONF = 11;
  localparam int F_EXT = 12;
  localparam logic [NUM_FLT-1:0] WARN_MASK = 13'h001f;
  localparam logic [NUM_FLT-1:0] SELF_MASK = 13'h10e0;
  localparam logic [NUM_FLT-1:0] MAN_MASK = 13'h0f00;
  // Register byte addresses
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_MODTYPE = 8'h0c;
  localparam logic [7:0] A_LOGCNT = 8'h10;
  localparam logic [7:0] A_LOGDATA = 8'h14;
  localparam logic [7:0] A_MODINFO = 8'h18;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Command bits in A_CMD
  localparam int C_FAULT_RST = 0;
  localparam int C_NEW_MOD_ACK = 1;
  localparam int C_SAVE = 2;
  localparam int C_BACK = 3;
  localparam int C_HIST_RST = 4;
  // Control fields in A_CTRL
  localparam int K_UNINST_YES = 0;
  localparam int K_DATA_YES = 1;
  localparam int K_MOD_SEL = 2;
  localparam int K_DATA_SEL = 4;
  typedef enum logic [1:0] {ENG_RUN, ENG_COOL, ENG_OFF} eng_e;
endpackage

// ### sim/contactor_model.sv
// Far-side model: contactor position switches and accessory module bus
// Assumes the bench chooses the switch pattern and which modules sit on the bus
`timescale 1ns/1ps
module contactor_model (
  input wire logic clk,
  input wire logic [1:0] pos_mode,
  input wire logic [3:0] mod_mask,
  input wire logic [3:0] comm_mask,
  input wire logic [7:0] type_set,
  output logic pos_pref_sw,
  output logic pos_stby_sw,
  output logic [3:0] mod_present,
  output logic [3:0] mod_comm_ok,
  output logic [7:0] mod_type_in
);
  // ----------------------------------------
  // Switches and module lines
  // ----------------------------------------
  logic [7:0] churn_r = 8'h00;
  always_ff @(posedge clk) begin
    churn_r <= churn_r + 8'h5b;
    pos_pref_sw <= (pos_mode == 2'h0) || (pos_mode == 2'h2);
    pos_stby_sw <= (pos_mode == 2'h1) || (pos_mode == 2'h2);
    mod_present <= mod_mask;
    mod_comm_ok <= comm_mask & mod_mask;
    // An absent module leaves its type lines undriven, so they wander
    for (int i = 0; i < 4; i++) begin
      mod_type_in[2*i +: 2] <= mod_mask[i] ? type_set[2*i +: 2] : churn_r[2*i +: 2];
    end
  end
endmodule

// ### sim/transfer_fault_supervisor_bench.sv
// Self-checking bench for the transfer fault supervisor
// Assumes the contactor model on the far side and an APB requester task here
`timescale 1ns/1ps
module transfer_fault_supervisor_bench;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, xfer_cmd = 0, xfer_done_tmo = 0;
  logic src_avail_chg = 0, acq_stby_tmo = 0, acq_pref_tmo = 0, in_phase_monitor = 0;
  logic sync_tmo = 0, backup_battery_module_low = 0, rot_err_n = 0, rot_err_e = 0;
  logic ext_fault_in = 0, cooldown_done = 0, event_valid = 0, e, pready, pslverr;
  logic pos_pref_sw, pos_stby_sw, alert_led, common_fault, halt_xfer, modes_off;
  logic cooldown_start, engine_start, xfer_retry, check_mod_setup, seen;
  logic [7:0] paddr = 0, event_code = 0, type_set = 8'h03, mod_type_in;
  logic [31:0] pwdata = 0, prdata, q, seed = 32'h3f;
  logic [1:0] pos_mode = 0;
  logic [3:0] mod_mask = 0, comm_mask = 4'hf, fault_msg, data_reset_go, go_log = 4'h0;
  logic [3:0] mod_present, mod_comm_ok;
  logic [12:0] fault_out;
  int miscompares = 0, cmp_count = 0, cycles = 0, n;
  byte codes[$];
  always #5 clk = ~clk;
  fault_sup fault_sup_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pos_pref_sw, .pos_stby_sw, .xfer_cmd, .xfer_done_tmo, .src_avail_chg,
    .acq_stby_tmo, .acq_pref_tmo, .in_phase_monitor, .sync_tmo, .backup_battery_module_low,
    .rot_err_n, .rot_err_e, .mod_present, .mod_comm_ok, .mod_type_in, .ext_fault_in,
    .cooldown_done, .event_code, .event_valid, .alert_led, .fault_out, .common_fault,
    .fault_msg, .halt_xfer, .modes_off, .cooldown_start, .engine_start, .xfer_retry,
    .check_mod_setup, .data_reset_go);
  contactor_model contactor_model_inst (.clk, .pos_mode, .mod_mask, .comm_mask, .type_set,
    .pos_pref_sw, .pos_stby_sw, .mod_present, .mod_comm_ok, .mod_type_in);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always @(posedge clk) if (data_reset_go !== 4'h0) go_log <= go_log | data_reset_go;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] msg_of(input logic [12:0] f);
    for (int i = 0; i < 13; i++) if (f[i]) return i[3:0];
    return 4'hf;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic exp_state(input logic [12:0] f);
    int k;
    k = 0;
    while (fault_out !== f && k < 40) begin @(posedge clk); k++; end
    repeat (2) @(posedge clk);
    chk("fault_out", {19'h0, f}, {19'h0, fault_out});
    chk("common_fault", {31'h0, |f}, {31'h0, common_fault});
    chk("fault_msg", {28'h0, msg_of(f)}, {28'h0, fault_msg});
    chk("alert_led", {31'h0, |f}, {31'h0, alert_led});
    chk("modes_off", |(f & ~fault_sup_pkg::WARN_MASK), {31'h0, modes_off});
    chk("halt_xfer", |(f & fault_sup_pkg::MAN_MASK), {31'h0, halt_xfer});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic cmd(input int b);
    apb(1, fault_sup_pkg::A_CMD, 32'h1 << b);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin miscompares++; end_of_test(); end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    exp_state(0);
    chk("engine_start", 1, {31'h0, engine_start});
    ext_fault_in <= 1;
    seen = 0;
    for (n = 0; n < 40 && !seen; n++) @(posedge clk) seen = cooldown_start;
    chk("cooldown_start", 1, {31'h0, seen});
    exp_state(13'h1 << fault_sup_pkg::F_EXT);
    chk("engine_start", 1, {31'h0, engine_start});
    cooldown_done <= 1;
    @(posedge clk) cooldown_done <= 0;
    for (n = 0; n < 20 && engine_start !== 1'b0; n++) @(posedge clk);
    chk("engine_start", 0, {31'h0, engine_start});
    apb(0, fault_sup_pkg::A_STATUS, 0);
    chk("status", 32'h1 << fault_sup_pkg::F_EXT, q);
    ext_fault_in <= 0;
    exp_state(0);
    for (int i = 0; i < 2; i++) begin
      rot_err_n <= (i == 0); rot_err_e <= (i == 1);
      exp_state(13'h1 << (fault_sup_pkg::F_ROT_N + i));
    end
    rot_err_e <= 0;
    exp_state(0);
    pos_mode <= 2;
    @(posedge clk) pos_mode <= 0;
    repeat (8) @(posedge clk);
    exp_state(0);
    for (int m = 1; m < 4; m++) begin
      pos_mode <= m[1:0];
      exp_state(13'h1 << (m == 3 ? fault_sup_pkg::F_AUX_OPEN : fault_sup_pkg::F_AUX));
      pos_mode <= 0;
      repeat (10) @(posedge clk);
      cmd(fault_sup_pkg::C_FAULT_RST);
      exp_state(0);
      chk("alert_led", 0, {31'h0, alert_led});
    end
    mod_mask <= 4'h1;
    exp_state(13'h1 << fault_sup_pkg::F_MOD_CHG);
    cmd(fault_sup_pkg::C_NEW_MOD_ACK);
    cmd(fault_sup_pkg::C_FAULT_RST);
    exp_state(0);
    apb(0, fault_sup_pkg::A_MODTYPE, 0);
    chk("modtype", fault_sup_pkg::HIGH_POWER_IO_BOARD_TYPE, {30'h0, q[1:0]});
    comm_mask <= 0;
    exp_state(13'h1 << fault_sup_pkg::F_COMM);
    comm_mask <= 4'hf;
    exp_state(0);
    type_set <= 8'h01;
    exp_state(13'h1 << fault_sup_pkg::F_MOD_CONF);
    type_set <= 8'h03;
    cmd(fault_sup_pkg::C_FAULT_RST);
    exp_state(0);
    mod_mask <= 0;
    repeat (12) @(posedge clk);
    cmd(fault_sup_pkg::C_FAULT_RST);
    repeat (3) @(posedge clk);
    chk("modchg_kept", 1, {31'h0, fault_out[fault_sup_pkg::F_MOD_CHG]});
    chk("check_mod_setup", 1, {31'h0, check_mod_setup});
    apb(1, fault_sup_pkg::A_CTRL, 32'h1);
    cmd(fault_sup_pkg::C_SAVE);
    cmd(fault_sup_pkg::C_FAULT_RST);
    exp_state(0);
    apb(0, fault_sup_pkg::A_MODINFO, 0);
    chk("modinfo", 0, q);
    backup_battery_module_low <= 1;
    exp_state(13'h1 << fault_sup_pkg::F_BATT);
    backup_battery_module_low <= 0;
    src_avail_chg <= 1; acq_stby_tmo <= 1; acq_pref_tmo <= 1;
    @(posedge clk) src_avail_chg <= 0;
    @(posedge clk) acq_stby_tmo <= 0; acq_pref_tmo <= 0;
    exp_state(13'h3);
    sync_tmo <= 1;
    @(posedge clk) sync_tmo <= 0;
    exp_state(13'h7);
    in_phase_monitor <= 1;
    exp_state(13'h3);
    src_avail_chg <= 1;
    @(posedge clk) src_avail_chg <= 0;
    exp_state(0);
    xfer_cmd <= 1;
    @(posedge clk) xfer_cmd <= 0;
    for (int t = 0; t < 3; t++) begin
      xfer_done_tmo <= 1;
      @(posedge clk) xfer_done_tmo <= 0;
      seen = 0;
      repeat (6) @(posedge clk) seen = seen | xfer_retry;
      chk("xfer_retry", (t < 2), {31'h0, seen});
      exp_state(t == 2 ? 13'h1 << fault_sup_pkg::F_FTT : 13'h0);
    end
    for (int s = 0; s < 6; s++) begin
      apb(1, fault_sup_pkg::A_CTRL, ((s % 4) << 4) | (s == 5 ? 0 : 2));
      go_log = 4'h0;
      cmd(s == 4 ? fault_sup_pkg::C_BACK : fault_sup_pkg::C_SAVE);
      repeat (3) @(posedge clk);
      chk("data_reset_go", s < 4 ? 4'h1 << s : 4'h0, {28'h0, go_log});
    end
    cmd(fault_sup_pkg::C_HIST_RST);
    apb(0, fault_sup_pkg::A_LOGCNT, 0);
    chk("logcnt", 0, q);
    n = xs() % 8 + 1;
    repeat (n) begin
      codes.push_back(byte'(xs()));
      event_code <= codes[$]; event_valid <= 1;
      @(posedge clk);
    end
    event_valid <= 0;
    apb(0, fault_sup_pkg::A_LOGCNT, 0);
    chk("logcnt", codes.size(), q);
    foreach (codes[i]) begin
      apb(1, fault_sup_pkg::A_LOGCNT, i);
      apb(0, fault_sup_pkg::A_LOGDATA, 0);
      chk("logdata", {24'h0, codes[i]}, q);
    end
    apb(0, 8'h1c, 0);
    chk("pslverr", 1, {31'h0, e});
    apb(0, 8'h02, 0);
    chk("pslverr", 1, {31'h0, e});
    end_of_test();
  end
endmodule
